// file: src/ripple_count_config_pkg.sv
// Constants shared by the ripple counting configuration block
package ripple_count_config_pkg;

	// Register port, limit and tally widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int LIMIT_W = 10;
	localparam int TALLY_W = 16;

	// Register offsets
	localparam logic [7:0] RIPPLE_CONFIG_ADDR = 8'h11;
	localparam logic [7:0] COUNT_LIMIT_LOW_ADDR = 8'h12;
	localparam logic [7:0] SCALING_CONFIG_ADDR = 8'h13;
	localparam logic [7:0] INVERSE_RESISTANCE_ADDR = 8'h14;
	localparam logic [7:0] BACK_EMF_VALUE_ADDR = 8'h15;
	localparam logic [7:0] BANDPASS_SETTING_ADDR = 8'h16;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Reset values
	localparam logic [7:0] RIPPLE_CONFIG_RST = 8'h88;
	localparam logic [7:0] COUNT_LIMIT_LOW_RST = 8'hff;
	localparam logic [7:0] SCALING_CONFIG_RST = 8'h7f;
	localparam logic [7:0] INVERSE_RESISTANCE_RST = 8'h00;
	localparam logic [7:0] BACK_EMF_VALUE_RST = 8'h00;
	localparam logic [7:0] BANDPASS_SETTING_RST = 8'h00;

	// Ripple configuration fields
	localparam int RIPPLE_COUNT_ENABLE_BIT = 7;
	localparam int CORRECTION_OFF_BIT = 6;
	localparam int BRIDGE_FLOAT_ON_LIMIT_BIT = 5;
	localparam int FILTER_INPUT_GAIN_HI = 4;
	localparam int FILTER_INPUT_GAIN_LO = 3;
	localparam int MIRROR_GAIN_HI = 2;
	localparam int MIRROR_GAIN_LO = 0;

	// Scaling configuration fields
	localparam int INV_RES_MULT_HI = 7;
	localparam int INV_RES_MULT_LO = 6;
	localparam int BACK_EMF_MULT_HI = 5;
	localparam int BACK_EMF_MULT_LO = 4;
	localparam int LIMIT_MULT_HI = 3;
	localparam int LIMIT_MULT_LO = 2;
	localparam int LIMIT_UPPER_HI = 1;
	localparam int LIMIT_UPPER_LO = 0;

	// Bandpass damping field
	localparam int BANDPASS_DAMPING_HI = 7;
	localparam int BANDPASS_DAMPING_LO = 4;

	// Filter input gain, as a value
	localparam logic [4:0] FILTER_GAIN_0 = 5'h02;
	localparam logic [4:0] FILTER_GAIN_1 = 5'h04;
	localparam logic [4:0] FILTER_GAIN_2 = 5'h08;
	localparam logic [4:0] FILTER_GAIN_3 = 5'h10;

	// Mirror gain as a right-shift of the 4 A/A setting (4 >> n)
	localparam logic [2:0] MIRROR_SHIFT_4 = 3'h0;
	localparam logic [2:0] MIRROR_SHIFT_2 = 3'h1;
	localparam logic [2:0] MIRROR_SHIFT_1 = 3'h2;
	localparam logic [2:0] MIRROR_SHIFT_HALF = 3'h3;
	localparam logic [2:0] MIRROR_SHIFT_QUARTER = 3'h4;
	localparam logic [2:0] MIRROR_SHIFT_EIGHTH = 3'h5;

	// Count limit multiplier, as a value
	localparam logic [6:0] LIMIT_MULT_0 = 7'h02;
	localparam logic [6:0] LIMIT_MULT_1 = 7'h08;
	localparam logic [6:0] LIMIT_MULT_2 = 7'h10;
	localparam logic [6:0] LIMIT_MULT_3 = 7'h40;

	// Inverse resistance multiplier, as a value
	localparam logic [13:0] INV_RES_MULT_0 = 14'h0002;
	localparam logic [13:0] INV_RES_MULT_1 = 14'h0040;
	localparam logic [13:0] INV_RES_MULT_2 = 14'h0400;
	localparam logic [13:0] INV_RES_MULT_3 = 14'h2000;

	// Back-EMF multiplier is 24 times two to this exponent
	localparam logic [3:0] BACK_EMF_EXP_0 = 4'h8;
	localparam logic [3:0] BACK_EMF_EXP_1 = 4'h9;
	localparam logic [3:0] BACK_EMF_EXP_2 = 4'hc;
	localparam logic [3:0] BACK_EMF_EXP_3 = 4'hd;

endpackage : ripple_count_config_pkg

// file: src/ripple_count_config.sv
// Ripple counting configuration registers, tally and limit compare
//
// Contract
// - Config bit 7 low stops the ripple tally; high lets it count.
// - Config bit 6 low keeps error correction on; high turns it off.
// - Tally past limit floats the bridge only when config bit 5 is set.
// - Config bits 4-3 pick filter input gain 2, 4, 8 or 16.
// - Config bits 2-0 pick mirror gain 4,2,1,0.5; 1X0 0.25, 1X1 0.125.
// - Ten-bit limit: low byte at 0x12, top two bits in 0x13 bits 1-0.
// - Tally is compared with limit times selected limit multiplier.
// - Scaling bits 3-2 pick limit multiplier 2, 8, 16 or 64.
// - Scaling bits 7-6 pick inverse resistance multiplier 2, 64, 1024, 8192.
// - Scaling bits 5-4 pick back-EMF multiplier 24 times 2^8,9,12,13.
// - Register 0x15 is used as the back-EMF constant.
// - Bits 7-4 at 0x16 set bandpass damping; bits 3-0 reserved.
// - Config resets to 0x88; other registers take their own reset values.
`timescale 1ns/1ps
`default_nettype none

module ripple_count_config (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Register port
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [ripple_count_config_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [ripple_count_config_pkg::DATA_W-1:0] reg_wdata_i,
	output logic [ripple_count_config_pkg::DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Ripple events from the detector
	input wire logic ripple_pulse_i,
	input wire logic tally_clear_i,
	// Tally and bridge
	output logic [ripple_count_config_pkg::TALLY_W-1:0] ripple_tally_o,
	output logic limit_passed_o,
	output logic bridge_float_o,
	// Settings to the analog and filter path
	output logic ripple_count_enable_o,
	output logic correction_active_o,
	output logic [4:0] filter_input_gain_o,
	output logic [2:0] mirror_gain_shift_o,
	output logic [6:0] count_limit_multiplier_o,
	output logic [13:0] inverse_resistance_multiplier_o,
	output logic [7:0] inverse_coil_resistance_o,
	output logic [3:0] back_emf_exponent_o,
	output logic [7:0] back_emf_factor_o,
	output logic [3:0] bandpass_damping_o
);
	import ripple_count_config_pkg::*;

	typedef struct packed {
		logic [7:0] ripple_config;
		logic [7:0] count_limit_low;
		logic [7:0] scaling_config;
		logic [7:0] inverse_resistance;
		logic [7:0] back_emf_value;
		logic [7:0] bandpass_setting;
		logic [TALLY_W-1:0] tally;
		logic passed;
		logic bridge_float;
		logic [7:0] rdata;
		logic rvalid;
		logic [4:0] filter_gain;
		logic [2:0] mirror_shift;
		logic [6:0] limit_mult;
		logic [13:0] inv_res_mult;
		logic [3:0] emf_exp;
	} state_type;

	localparam state_type STATE_RST = '{
		ripple_config: RIPPLE_CONFIG_RST,
		count_limit_low: COUNT_LIMIT_LOW_RST,
		scaling_config: SCALING_CONFIG_RST,
		inverse_resistance: INVERSE_RESISTANCE_RST,
		back_emf_value: BACK_EMF_VALUE_RST,
		bandpass_setting: BANDPASS_SETTING_RST,
		tally: '0,
		passed: 1'b0,
		bridge_float: 1'b0,
		rdata: UNMAPPED_READ,
		rvalid: 1'b0,
		filter_gain: FILTER_GAIN_1,
		mirror_shift: MIRROR_SHIFT_4,
		limit_mult: LIMIT_MULT_3,
		inv_res_mult: INV_RES_MULT_1,
		emf_exp: BACK_EMF_EXP_3
	};

	state_type state_r;
	state_type state_nxt;
	logic [LIMIT_W-1:0] limit;
	logic [TALLY_W-1:0] limit_eff;
	logic [TALLY_W-1:0] tally_base;
	logic count_on;

	always_comb begin
		state_nxt = state_r;
		limit = '0;
		limit_eff = '0;
		tally_base = '0;
		count_on = 1'b0;

		// Register writes; unmapped offsets are ignored
		if (reg_write_i) begin
			case (reg_addr_i)
				RIPPLE_CONFIG_ADDR: state_nxt.ripple_config = reg_wdata_i;
				COUNT_LIMIT_LOW_ADDR: state_nxt.count_limit_low = reg_wdata_i;
				SCALING_CONFIG_ADDR: state_nxt.scaling_config = reg_wdata_i;
				INVERSE_RESISTANCE_ADDR: state_nxt.inverse_resistance = reg_wdata_i;
				BACK_EMF_VALUE_ADDR: state_nxt.back_emf_value = reg_wdata_i;
				BANDPASS_SETTING_ADDR: state_nxt.bandpass_setting = reg_wdata_i;
				default: state_nxt.ripple_config = state_nxt.ripple_config;
			endcase
		end

		// Read data; reserved bits of the bandpass register read back as stored
		state_nxt.rvalid = reg_read_i;
		if (reg_read_i) begin
			case (reg_addr_i)
				RIPPLE_CONFIG_ADDR: state_nxt.rdata = state_r.ripple_config;
				COUNT_LIMIT_LOW_ADDR: state_nxt.rdata = state_r.count_limit_low;
				SCALING_CONFIG_ADDR: state_nxt.rdata = state_r.scaling_config;
				INVERSE_RESISTANCE_ADDR: state_nxt.rdata = state_r.inverse_resistance;
				BACK_EMF_VALUE_ADDR: state_nxt.rdata = state_r.back_emf_value;
				BANDPASS_SETTING_ADDR: state_nxt.rdata = state_r.bandpass_setting;
				default: state_nxt.rdata = UNMAPPED_READ;
			endcase
		end

		// Filter input gain
		case (state_r.ripple_config[FILTER_INPUT_GAIN_HI:FILTER_INPUT_GAIN_LO])
			2'h0: state_nxt.filter_gain = FILTER_GAIN_0;
			2'h1: state_nxt.filter_gain = FILTER_GAIN_1;
			2'h2: state_nxt.filter_gain = FILTER_GAIN_2;
			default: state_nxt.filter_gain = FILTER_GAIN_3;
		endcase

		// Mirror gain; bit 1 carries no meaning once bit 2 is set
		if (state_r.ripple_config[MIRROR_GAIN_HI]) begin
			if (state_r.ripple_config[MIRROR_GAIN_LO]) begin
				state_nxt.mirror_shift = MIRROR_SHIFT_EIGHTH;
			end else begin
				state_nxt.mirror_shift = MIRROR_SHIFT_QUARTER;
			end
		end else begin
			case (state_r.ripple_config[MIRROR_GAIN_HI-1:MIRROR_GAIN_LO])
				2'h0: state_nxt.mirror_shift = MIRROR_SHIFT_4;
				2'h1: state_nxt.mirror_shift = MIRROR_SHIFT_2;
				2'h2: state_nxt.mirror_shift = MIRROR_SHIFT_1;
				default: state_nxt.mirror_shift = MIRROR_SHIFT_HALF;
			endcase
		end

		// Count limit multiplier
		case (state_r.scaling_config[LIMIT_MULT_HI:LIMIT_MULT_LO])
			2'h0: state_nxt.limit_mult = LIMIT_MULT_0;
			2'h1: state_nxt.limit_mult = LIMIT_MULT_1;
			2'h2: state_nxt.limit_mult = LIMIT_MULT_2;
			default: state_nxt.limit_mult = LIMIT_MULT_3;
		endcase

		// Inverse resistance multiplier
		case (state_r.scaling_config[INV_RES_MULT_HI:INV_RES_MULT_LO])
			2'h0: state_nxt.inv_res_mult = INV_RES_MULT_0;
			2'h1: state_nxt.inv_res_mult = INV_RES_MULT_1;
			2'h2: state_nxt.inv_res_mult = INV_RES_MULT_2;
			default: state_nxt.inv_res_mult = INV_RES_MULT_3;
		endcase

		// Back-EMF multiplier exponent
		case (state_r.scaling_config[BACK_EMF_MULT_HI:BACK_EMF_MULT_LO])
			2'h0: state_nxt.emf_exp = BACK_EMF_EXP_0;
			2'h1: state_nxt.emf_exp = BACK_EMF_EXP_1;
			2'h2: state_nxt.emf_exp = BACK_EMF_EXP_2;
			default: state_nxt.emf_exp = BACK_EMF_EXP_3;
		endcase

		// Effective limit uses the decoded multiplier already in the state
		limit = {state_r.scaling_config[LIMIT_UPPER_HI:LIMIT_UPPER_LO],
			state_r.count_limit_low};
		// Widen both factors first; a 10-bit product would wrap at large limits
		limit_eff = TALLY_W'(limit) * TALLY_W'(state_r.limit_mult);

		// Tally; a ripple in the clear cycle is kept, saturates at the top
		count_on = state_r.ripple_config[RIPPLE_COUNT_ENABLE_BIT];
		tally_base = tally_clear_i ? '0 : state_r.tally;
		if (count_on && ripple_pulse_i && (tally_base != {TALLY_W{1'b1}})) begin
			state_nxt.tally = tally_base + TALLY_W'(1);
		end else begin
			state_nxt.tally = tally_base;
		end

		// Strict compare on the registered tally, every cycle
		state_nxt.passed = (state_r.tally > limit_eff);
		state_nxt.bridge_float = (state_r.tally > limit_eff) &&
			state_r.ripple_config[BRIDGE_FLOAT_ON_LIMIT_BIT];
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= STATE_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign reg_rdata_o = state_r.rdata;
	assign reg_rvalid_o = state_r.rvalid;
	assign ripple_tally_o = state_r.tally;
	assign limit_passed_o = state_r.passed;
	assign bridge_float_o = state_r.bridge_float;
	assign ripple_count_enable_o = state_r.ripple_config[RIPPLE_COUNT_ENABLE_BIT];
	// Inverted sense: a set bit means correction is off
	assign correction_active_o = ~state_r.ripple_config[CORRECTION_OFF_BIT];
	assign filter_input_gain_o = state_r.filter_gain;
	assign mirror_gain_shift_o = state_r.mirror_shift;
	assign count_limit_multiplier_o = state_r.limit_mult;
	assign inverse_resistance_multiplier_o = state_r.inv_res_mult;
	// Zero here is a software fault; passed through untouched
	assign inverse_coil_resistance_o = state_r.inverse_resistance;
	assign back_emf_exponent_o = state_r.emf_exp;
	assign back_emf_factor_o = state_r.back_emf_value;
	assign bandpass_damping_o = state_r.bandpass_setting[BANDPASS_DAMPING_HI:BANDPASS_DAMPING_LO];

endmodule : ripple_count_config

`default_nettype wire

// file: testbench/ripple_count_config_checker.sv
// Port checker for the ripple counting configuration block
`timescale 1ns/1ps
`default_nettype none
module ripple_count_config_checker
	import ripple_count_config_pkg::*;
(
	// Clock, reset, register port
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rvalid_o,
	// Ripple path
	input wire logic ripple_pulse_i,
	input wire logic tally_clear_i,
	input wire logic [15:0] ripple_tally_o,
	input wire logic limit_passed_o,
	input wire logic bridge_float_o,
	// Settings
	input wire logic ripple_count_enable_o,
	input wire logic correction_active_o,
	input wire logic [4:0] filter_input_gain_o,
	input wire logic [2:0] mirror_gain_shift_o,
	input wire logic [7:0] back_emf_factor_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic cfg_wr;
	assign cfg_wr = reg_write_i && reg_addr_i == RIPPLE_CONFIG_ADDR;
	read_answer_a: assert property (reg_read_i |=> reg_rvalid_o) else $error("no rvalid");
	stray_valid_a: assert property (!reg_read_i |=> !reg_rvalid_o) else $error("stray rvalid");
	count_enable_a: assert property (cfg_wr |-> ##2 ripple_count_enable_o == $past(reg_wdata_i[7], 2))
		else $error("enable map");
	correction_map_a: assert property (cfg_wr |-> ##2 correction_active_o != $past(reg_wdata_i[6], 2))
		else $error("correction map");
	filter_gain_a: assert property (cfg_wr |-> ##2 filter_input_gain_o == 5'h02 << $past(reg_wdata_i[4:3], 2))
		else $error("filter gain");
	mirror_low_a: assert property (cfg_wr && reg_wdata_i[2] |-> ##2 mirror_gain_shift_o == {2'h2, $past(reg_wdata_i[0], 2)})
		else $error("mirror gain");
	tally_step_a: assert property ($past(ripple_pulse_i && !tally_clear_i && ripple_count_enable_o)
		&& $past(ripple_tally_o) != 16'hffff
		|-> ripple_tally_o == $past(ripple_tally_o) + 16'h1) else $error("tally step");
	tally_hold_a: assert property ($past(!ripple_count_enable_o && !tally_clear_i) |-> $stable(ripple_tally_o))
		else $error("tally moved");
	float_pass_a: assert property (bridge_float_o |-> limit_passed_o) else $error("float without pass");
	strict_pass_a: assert property (limit_passed_o |-> $past(ripple_tally_o) != 16'h0) else $error("pass at zero");
	emf_value_a: assert property (reg_write_i && reg_addr_i == BACK_EMF_VALUE_ADDR
		|-> ##2 back_emf_factor_o == $past(reg_wdata_i, 2)) else $error("back emf");
endmodule // ripple_count_config_checker
`default_nettype wire

// file: testbench/ripple_count_config_bench.sv
// Self-checking bench for the ripple counting configuration block
`timescale 1ns/1ps
`default_nettype none
module ripple_count_config_bench;
	import ripple_count_config_pkg::*;
	logic clk_i = 0, nrst_i = 0, reg_write_i = 0, reg_read_i = 0;
	logic ripple_pulse_i = 0, tally_clear_i = 0, reg_rvalid_o;
	logic limit_passed_o, bridge_float_o, ripple_count_enable_o, correction_active_o;
	logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
	logic [7:0] inverse_coil_resistance_o, back_emf_factor_o;
	logic [15:0] ripple_tally_o;
	logic [4:0] filter_input_gain_o;
	logic [2:0] mirror_gain_shift_o;
	logic [6:0] count_limit_multiplier_o;
	logic [13:0] inverse_resistance_multiplier_o;
	logic [3:0] back_emf_exponent_o, bandpass_damping_o;
	logic [7:0] rst_tab [6] = '{8'h88, 8'hff, 8'h7f, 8'h00, 8'h00, 8'h00};
	logic [13:0] irm [4] = '{14'h0002, 14'h0040, 14'h0400, 14'h2000};
	logic [3:0] bex [4] = '{4'h8, 4'h9, 4'hc, 4'hd};
	logic [6:0] lmm [4] = '{7'h02, 7'h08, 7'h10, 7'h40};
	int error_cnt = 0, compares = 0;
	ripple_count_config dut_u (.*);
	always #2.5 clk_i = ~clk_i;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Strobe low for a cycle so back-to-back calls never reassign it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_write_i = 1;
		reg_addr_i = a;
		reg_wdata_i = d;
		step(1);
		reg_write_i = 0;
		step(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_read_i = 1;
		reg_addr_i = a;
		step(1);
		check(reg_rvalid_o, 1'b1);
		check(reg_rdata_o, exp);
		reg_read_i = 0;
		step(1);
	endtask
	task automatic pulse(input int n);
		ripple_pulse_i = 1;
		step(n);
		ripple_pulse_i = 0;
		step(1);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 6; i++) rd(8'h11 + i[7:0], rst_tab[i]);
		rd(8'h20, 8'h00);
		check(correction_active_o, 1'b1);
		check(count_limit_multiplier_o, 7'h40);
	endtask
	task automatic t_config;
		logic [7:0] d;
		for (int i = 0; i < 8; i++) begin
			d = {i[1], i[0], 1'b0, i[1:0], i[2:0]};
			wr(RIPPLE_CONFIG_ADDR, d);
			check(ripple_count_enable_o, d[7]);
			check(correction_active_o, !d[6]);
			check(filter_input_gain_o, 5'h02 << d[4:3]);
			check(mirror_gain_shift_o, d[2] ? {2'h2, d[0]} : {1'b0, d[1:0]});
			rd(RIPPLE_CONFIG_ADDR, d);
		end
		for (int j = 0; j < 4; j++) begin
			wr(SCALING_CONFIG_ADDR, {j[1:0], j[1:0], j[1:0], 2'h0});
			check(inverse_resistance_multiplier_o, irm[j]);
			check(back_emf_exponent_o, bex[j]);
			check(count_limit_multiplier_o, lmm[j]);
		end
		wr(INVERSE_RESISTANCE_ADDR, 8'h5a);
		wr(BACK_EMF_VALUE_ADDR, 8'ha5);
		wr(BANDPASS_SETTING_ADDR, 8'h6c);
		check(inverse_coil_resistance_o, 8'h5a);
		check(back_emf_factor_o, 8'ha5);
		check(bandpass_damping_o, 4'h6);
		rd(BANDPASS_SETTING_ADDR, 8'h6c);
	endtask
	// Limit of 1 times 2: a tally of 2 must not pass, 3 must
	task automatic t_limit;
		wr(COUNT_LIMIT_LOW_ADDR, 8'h01);
		wr(SCALING_CONFIG_ADDR, 8'h00);
		wr(RIPPLE_CONFIG_ADDR, 8'ha8);
		tally_clear_i = 1;
		step(1);
		tally_clear_i = 0;
		pulse(2);
		check(ripple_tally_o, 16'h2);
		check(limit_passed_o, 1'b0);
		pulse(1);
		check(limit_passed_o, 1'b1);
		check(bridge_float_o, 1'b1);
		wr(RIPPLE_CONFIG_ADDR, 8'h88);
		step(1);
		check(bridge_float_o, 1'b0);
		wr(SCALING_CONFIG_ADDR, 8'h04);
		step(1);
		check(limit_passed_o, 1'b0);
		wr(RIPPLE_CONFIG_ADDR, 8'h08);
		pulse(3);
		check(ripple_tally_o, 16'h3);
		nrst_i = 0;
		step(2);
		check(ripple_tally_o, 16'h0);
		nrst_i = 1;
		step(1);
		rd(RIPPLE_CONFIG_ADDR, 8'h88);
	endtask
	task automatic final_report;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		step(6);
		nrst_i = 1;
		step(1);
		t_reset();
		t_config();
		t_limit();
		final_report();
	end
	initial begin
		#50000;
		error_cnt++;
		final_report();
	end
endmodule // ripple_count_config_bench
bind ripple_count_config ripple_count_config_checker chk_u (.*);
`default_nettype wire
